// ===== core/dopcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: channel A offset from 0x14 and 0x16[7:3]
// RULE_02: channel B offset from 0x15 and 0x17[7:3]
// RULE_03: offset counts in converter output LSBs
// RULE_04: writing 0x14 loads both offsets together
// RULE_05: other offset writes only touch holding storage
// RULE_06: host writes 0x14 last in updates
// RULE_07: 0x17 bit 2 selects four-wire port
// RULE_08: 0x17 bits 1/0 sleep clock paths
// RULE_09: host keeps needed clock paths running
// RULE_10: 0x18 bit 7 sensor enable, on at reset
// RULE_11: 0x18 bit 6 sleeps clock, strobe receivers
// RULE_12: 0x18 bits 3/2 sleep cores B/A
// RULE_13: 0x19 bit 2 selects external reference
// RULE_14: host preserves reserved bit defaults
module dopcr_regs #(
    parameter int OFFSET_WIDTH = dopcr_pkg::OFS_WIDTH,
    parameter int CHANNEL_COUNT = dopcr_pkg::CHANNELS
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [dopcr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [dopcr_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic SERIAL_READ_DATA,
    input wire logic ALARM_LEVEL,
    output logic [dopcr_pkg::DATA_W-1:0] REG_RDATA,
    output logic REG_RDATA_VALID,
    output logic [dopcr_pkg::OFS_WIDTH-1:0] OFFSET_A,
    output logic [dopcr_pkg::OFS_WIDTH-1:0] OFFSET_B,
    output logic OFFSET_LOAD,
    output logic FOUR_WIRE_PORT_SELECT,
    output logic ALARM_PIN_OUT,
    output logic CLKPATH_SLEEP_A,
    output logic CLKPATH_SLEEP_B,
    output logic TEMP_SENSOR_ENABLE,
    output logic CLOCK_RECEIVER_SLEEP,
    output logic SYNC_STROBE_INPUT_SLEEP,
    output logic DAC_CORE_A_SLEEP,
    output logic DAC_CORE_B_SLEEP,
    output logic EXTERNAL_REFERENCE_SELECT
);
    import dopcr_pkg::*;

    dopcr_state_t state_reg;
    dopcr_state_t state_next;
    logic [OFFSET_WIDTH-1:0] held [CHANNEL_COUNT];
    logic [OFFSET_WIDTH-1:0] active [CHANNEL_COUNT];

    ////////////////////////////////////////////////////////////////////////
    // refuse layouts that the register map cannot hold
    generate
        if (OFFSET_WIDTH != OFS_LOW_W + OFS_HI_MSB - OFS_HI_LSB + 1) begin : g_bad_width
            $error("offset width must be the low byte plus the upper field");
        end
        if (OFFSET_WIDTH != OFS_WIDTH) begin : g_bad_port_width
            $error("offset width must match the offset output ports");
        end
        if (CHANNEL_COUNT != CHANNELS) begin : g_bad_channels
            $error("only the two mapped offset channels are served");
        end
        if (DATA_W != OFS_LOW_W) begin : g_bad_data
            $error("register data must be one offset low byte wide");
        end
        if (ADDR_W != DATA_W) begin : g_bad_addr
            $error("register addresses must be one byte wide");
        end
        if (OFS_HI_MSB >= DATA_W || OFS_HI_LSB > OFS_HI_MSB) begin : g_bad_field
            $error("upper offset field must lie inside one register byte");
        end
        if (BIT_TEMP_SENSOR_ENABLE >= DATA_W || BIT_CLOCK_RECEIVER_SLEEP >= DATA_W
            || BIT_FOUR_WIRE_PORT_SELECT >= DATA_W) begin : g_bad_bit
            $error("control bit positions must lie inside one register byte");
        end
        if (ADDR_FACTORY_RESERVED - ADDR_OFFSET_A_LOW != 8'h06) begin : g_bad_map
            $error("register map must be seven consecutive addresses");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // holding words, low byte plus upper five bits
    assign held[0] = {state_reg.offset_a_high_bits[OFS_HI_MSB:OFS_HI_LSB],
                      state_reg.offset_a_low_byte};  // see RULE_01
    assign held[1] = {state_reg.offset_b_high_and_port_ctrl[OFS_HI_MSB:OFS_HI_LSB],
                      state_reg.offset_b_low_byte};  // see RULE_02

    ////////////////////////////////////////////////////////////////////////
    // register writes and reads
    always_comb begin
        state_next = state_reg;
        state_next.load = 1'b0;
        state_next.rvalid = 1'b0;
        ////////////////////////////////////////////////////////////////////
        // offset writes fill holding storage, control writes apply at once, 0x14 also raises the load event
        if (REG_WRITE) begin
            unique case (REG_ADDR)
                ADDR_OFFSET_A_LOW: begin
                    state_next.offset_a_low_byte = REG_WDATA;
                    state_next.load = 1'b1;  // see RULE_04
                end
                ADDR_OFFSET_B_LOW: begin
                    state_next.offset_b_low_byte = REG_WDATA;  // see RULE_05
                end
                ADDR_OFFSET_A_HIGH: begin
                    state_next.offset_a_high_bits = REG_WDATA;  // see RULE_05
                end
                ADDR_OFFSET_B_HIGH_PORT: begin
                    state_next.offset_b_high_and_port_ctrl = REG_WDATA;  // see RULE_05
                end
                ADDR_SENSOR_SLEEP: begin
                    state_next.sensor_and_sleep_ctrl = REG_WDATA;
                end
                ADDR_REFERENCE_SELECT: begin
                    state_next.reference_select = REG_WDATA;
                end
                ADDR_FACTORY_RESERVED: begin
                    state_next.factory_reserved_block = REG_WDATA;
                end
                default: begin
                end
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // reads return the stored byte, the old one on a same-cycle write
        if (REG_READ) begin
            state_next.rvalid = 1'b1;
            unique case (REG_ADDR)
                ADDR_OFFSET_A_LOW: begin
                    state_next.rdata = state_reg.offset_a_low_byte;
                end
                ADDR_OFFSET_B_LOW: begin
                    state_next.rdata = state_reg.offset_b_low_byte;
                end
                ADDR_OFFSET_A_HIGH: begin
                    state_next.rdata = state_reg.offset_a_high_bits;
                end
                ADDR_OFFSET_B_HIGH_PORT: begin
                    state_next.rdata = state_reg.offset_b_high_and_port_ctrl;
                end
                ADDR_SENSOR_SLEEP: begin
                    state_next.rdata = state_reg.sensor_and_sleep_ctrl;
                end
                ADDR_REFERENCE_SELECT: begin
                    state_next.rdata = state_reg.reference_select;
                end
                ADDR_FACTORY_RESERVED: begin
                    state_next.rdata = state_reg.factory_reserved_block;
                end
                default: begin
                    state_next.rdata = UNMAPPED_READ;
                end
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // alarm pin carries read data only in four-wire mode
        if (state_reg.offset_b_high_and_port_ctrl[BIT_FOUR_WIRE_PORT_SELECT]) begin
            state_next.alarm_pin = SERIAL_READ_DATA;  // see RULE_07
        end else begin
            state_next.alarm_pin = ALARM_LEVEL;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_reg.offset_a_low_byte <= RST_OFFSET_A_LOW;
            state_reg.offset_b_low_byte <= RST_OFFSET_B_LOW;
            state_reg.offset_a_high_bits <= RST_OFFSET_A_HIGH;
            state_reg.offset_b_high_and_port_ctrl <= RST_OFFSET_B_HIGH_PORT;
            state_reg.sensor_and_sleep_ctrl <= RST_SENSOR_SLEEP;  // see RULE_10
            state_reg.reference_select <= RST_REFERENCE_SELECT;
            state_reg.factory_reserved_block <= RST_FACTORY_RESERVED;
            state_reg.load <= 1'b0;
            state_reg.rdata <= RST_READ_DATA;
            state_reg.rvalid <= 1'b0;
            state_reg.alarm_pin <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active offset words, one per channel, in output LSBs
    generate
        for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_chan
            dopcr_offset_buf #(
                .WIDTH(OFFSET_WIDTH)
            ) u_buf (
                .CLOCK(CLOCK),
                .RESET(RESET),
                .load(state_reg.load),  // see RULE_04
                .held(held[ch]),
                .active(active[ch])  // see RULE_03
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign REG_RDATA = state_reg.rdata;
    assign REG_RDATA_VALID = state_reg.rvalid;
    assign OFFSET_A = active[0];
    assign OFFSET_B = active[1];
    assign OFFSET_LOAD = state_reg.load;
    assign FOUR_WIRE_PORT_SELECT =
        state_reg.offset_b_high_and_port_ctrl[BIT_FOUR_WIRE_PORT_SELECT];  // see RULE_07
    assign ALARM_PIN_OUT = state_reg.alarm_pin;
    assign CLKPATH_SLEEP_A =
        state_reg.offset_b_high_and_port_ctrl[BIT_CLKPATH_SLEEP_A];  // see RULE_08
    assign CLKPATH_SLEEP_B =
        state_reg.offset_b_high_and_port_ctrl[BIT_CLKPATH_SLEEP_B];  // see RULE_08
    assign TEMP_SENSOR_ENABLE =
        state_reg.sensor_and_sleep_ctrl[BIT_TEMP_SENSOR_ENABLE];  // see RULE_10
    assign CLOCK_RECEIVER_SLEEP =
        state_reg.sensor_and_sleep_ctrl[BIT_CLOCK_RECEIVER_SLEEP];  // see RULE_11
    assign SYNC_STROBE_INPUT_SLEEP =
        state_reg.sensor_and_sleep_ctrl[BIT_CLOCK_RECEIVER_SLEEP];  // see RULE_11
    assign DAC_CORE_A_SLEEP = state_reg.sensor_and_sleep_ctrl[BIT_CORE_A_SLEEP];  // see RULE_12
    assign DAC_CORE_B_SLEEP = state_reg.sensor_and_sleep_ctrl[BIT_CORE_B_SLEEP];  // see RULE_12
    assign EXTERNAL_REFERENCE_SELECT =
        state_reg.reference_select[BIT_EXTERNAL_REFERENCE];  // see RULE_13
endmodule
`default_nettype wire

// ===== core/dopcr_pkg.sv
package dopcr_pkg;

    // register access port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // offset word layout
    localparam int OFS_WIDTH = 13;
    localparam int OFS_LOW_W = 8;
    localparam int OFS_HI_MSB = 7;
    localparam int OFS_HI_LSB = 3;
    localparam int CHANNELS = 2;

    // register offsets
    localparam logic [7:0] ADDR_OFFSET_A_LOW = 8'h14;
    localparam logic [7:0] ADDR_OFFSET_B_LOW = 8'h15;
    localparam logic [7:0] ADDR_OFFSET_A_HIGH = 8'h16;
    localparam logic [7:0] ADDR_OFFSET_B_HIGH_PORT = 8'h17;
    localparam logic [7:0] ADDR_SENSOR_SLEEP = 8'h18;
    localparam logic [7:0] ADDR_REFERENCE_SELECT = 8'h19;
    localparam logic [7:0] ADDR_FACTORY_RESERVED = 8'h1a;

    // reset values
    localparam logic [7:0] RST_OFFSET_A_LOW = 8'h00;
    localparam logic [7:0] RST_OFFSET_B_LOW = 8'h00;
    localparam logic [7:0] RST_OFFSET_A_HIGH = 8'h00;
    localparam logic [7:0] RST_OFFSET_B_HIGH_PORT = 8'h00;
    localparam logic [7:0] RST_SENSOR_SLEEP = 8'h83;
    localparam logic [7:0] RST_REFERENCE_SELECT = 8'h00;
    localparam logic [7:0] RST_FACTORY_RESERVED = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // bit positions
    localparam int BIT_FOUR_WIRE_PORT_SELECT = 2;
    localparam int BIT_CLKPATH_SLEEP_A = 1;
    localparam int BIT_CLKPATH_SLEEP_B = 0;
    localparam int BIT_TEMP_SENSOR_ENABLE = 7;
    localparam int BIT_CLOCK_RECEIVER_SLEEP = 6;
    localparam int BIT_CORE_B_SLEEP = 3;
    localparam int BIT_CORE_A_SLEEP = 2;
    localparam int BIT_EXTERNAL_REFERENCE = 2;

    typedef struct packed {
        logic [7:0] offset_a_low_byte;
        logic [7:0] offset_b_low_byte;
        logic [7:0] offset_a_high_bits;
        logic [7:0] offset_b_high_and_port_ctrl;
        logic [7:0] sensor_and_sleep_ctrl;
        logic [7:0] reference_select;
        logic [7:0] factory_reserved_block;
        logic load;
        logic [7:0] rdata;
        logic rvalid;
        logic alarm_pin;
    } dopcr_state_t;

endpackage

// ===== core/dopcr_offset_buf.sv
`timescale 1ns/1ps
`default_nettype none
module dopcr_offset_buf #(
    parameter int WIDTH = 13
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic load,
    input wire logic [WIDTH-1:0] held,
    output logic [WIDTH-1:0] active
);
    import dopcr_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] active;
    } dopcr_buf_t;

    dopcr_buf_t state_reg;
    dopcr_buf_t state_next;

    generate
        if (WIDTH != OFS_WIDTH) begin : g_bad_width
            $error("offset width must match the register layout");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // active word changes only on the load event
    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.active = held;  // see RULE_04
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active = state_reg.active;
endmodule
`default_nettype wire

// ===== verif/dopcr_props.sv
`timescale 1ns/1ps
`default_nettype none
module dopcr_props (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic SERIAL_READ_DATA,
    input wire logic ALARM_LEVEL,
    input wire logic [12:0] OFFSET_A,
    input wire logic [12:0] OFFSET_B,
    input wire logic OFFSET_LOAD,
    input wire logic FOUR_WIRE_PORT_SELECT,
    input wire logic ALARM_PIN_OUT,
    input wire logic CLKPATH_SLEEP_A,
    input wire logic CLKPATH_SLEEP_B,
    input wire logic TEMP_SENSOR_ENABLE,
    input wire logic CLOCK_RECEIVER_SLEEP,
    input wire logic SYNC_STROBE_INPUT_SLEEP,
    input wire logic DAC_CORE_A_SLEEP,
    input wire logic DAC_CORE_B_SLEEP,
    input wire logic EXTERNAL_REFERENCE_SELECT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    sequence s_wr(logic [7:0] a);
        REG_WRITE && REG_ADDR == a;
    endsequence
    sequence s_load;
        s_wr(8'h14) ##1 OFFSET_LOAD;
    endsequence
    a_load_pulse: assert property (s_wr(8'h14) |=> OFFSET_LOAD)
        else $error("load event missing");
    a_load_cause: assert property (
        OFFSET_LOAD |-> $past(REG_WRITE && REG_ADDR == 8'h14))
        else $error("load event without low byte write");
    a_offset_hold: assert property (
        !OFFSET_LOAD |=> $stable(OFFSET_A) && $stable(OFFSET_B))
        else $error("active offset moved without load");
    a_offset_word: assert property (
        s_load |=> OFFSET_A[7:0] == $past(REG_WDATA, 2))
        else $error("offset low byte not applied");
    a_port_bits: assert property (
        s_wr(8'h17) |=> {FOUR_WIRE_PORT_SELECT, CLKPATH_SLEEP_A, CLKPATH_SLEEP_B}
        == $past(REG_WDATA[2:0]))
        else $error("port or clock path bits wrong");
    a_alarm_route: assert property (
        !$past(RESET) && $stable(FOUR_WIRE_PORT_SELECT) |->
        ALARM_PIN_OUT == ($past(FOUR_WIRE_PORT_SELECT) ? $past(SERIAL_READ_DATA)
        : $past(ALARM_LEVEL)))
        else $error("alarm pin source wrong");
    a_sense_recv: assert property (
        s_wr(8'h18) |=> TEMP_SENSOR_ENABLE == $past(REG_WDATA[7])
        && CLOCK_RECEIVER_SLEEP == $past(REG_WDATA[6]))
        else $error("sensor or receiver bit wrong");
    a_strobe_tied: assert property (
        CLOCK_RECEIVER_SLEEP == SYNC_STROBE_INPUT_SLEEP)
        else $error("strobe receiver sleep differs");
    a_core_sleep: assert property (
        s_wr(8'h18) |=> DAC_CORE_A_SLEEP == $past(REG_WDATA[2])
        && DAC_CORE_B_SLEEP == $past(REG_WDATA[3]))
        else $error("core sleep bits wrong");
    a_ref_select: assert property (
        s_wr(8'h19) |=> EXTERNAL_REFERENCE_SELECT == $past(REG_WDATA[2]))
        else $error("reference select wrong");
endmodule
`default_nettype wire

// ===== verif/dopcr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dopcr_regs_tb_top;
    logic CLOCK = 0, RESET = 1, REG_WRITE = 0, REG_READ = 0, SERIAL_READ_DATA = 0, ALARM_LEVEL = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
    logic [12:0] OFFSET_A, OFFSET_B;
    logic REG_RDATA_VALID, OFFSET_LOAD, FOUR_WIRE_PORT_SELECT, ALARM_PIN_OUT, CLKPATH_SLEEP_A;
    logic CLKPATH_SLEEP_B, TEMP_SENSOR_ENABLE, CLOCK_RECEIVER_SLEEP, SYNC_STROBE_INPUT_SLEEP;
    logic DAC_CORE_A_SLEEP, DAC_CORE_B_SLEEP, EXTERNAL_REFERENCE_SELECT;
    int n_mismatch = 0, checks_done = 0;
    logic [7:0] v17 [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
    logic [7:0] v18 [4] = '{8'h43, 8'h0b, 8'h07, 8'h83};
    logic [7:0] v19 [4] = '{8'h04, 8'h00, 8'h04, 8'h00};
    wire logic [8:0] ctrl = {FOUR_WIRE_PORT_SELECT, CLKPATH_SLEEP_A, CLKPATH_SLEEP_B,
        TEMP_SENSOR_ENABLE, CLOCK_RECEIVER_SLEEP, SYNC_STROBE_INPUT_SLEEP, DAC_CORE_B_SLEEP,
        DAC_CORE_A_SLEEP, EXTERNAL_REFERENCE_SELECT};
    dopcr_regs uut (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_WRITE(REG_WRITE),
        .REG_READ(REG_READ),
        .SERIAL_READ_DATA(SERIAL_READ_DATA),
        .ALARM_LEVEL(ALARM_LEVEL),
        .REG_RDATA(REG_RDATA),
        .REG_RDATA_VALID(REG_RDATA_VALID),
        .OFFSET_A(OFFSET_A),
        .OFFSET_B(OFFSET_B),
        .OFFSET_LOAD(OFFSET_LOAD),
        .FOUR_WIRE_PORT_SELECT(FOUR_WIRE_PORT_SELECT),
        .ALARM_PIN_OUT(ALARM_PIN_OUT),
        .CLKPATH_SLEEP_A(CLKPATH_SLEEP_A),
        .CLKPATH_SLEEP_B(CLKPATH_SLEEP_B),
        .TEMP_SENSOR_ENABLE(TEMP_SENSOR_ENABLE),
        .CLOCK_RECEIVER_SLEEP(CLOCK_RECEIVER_SLEEP),
        .SYNC_STROBE_INPUT_SLEEP(SYNC_STROBE_INPUT_SLEEP),
        .DAC_CORE_A_SLEEP(DAC_CORE_A_SLEEP),
        .DAC_CORE_B_SLEEP(DAC_CORE_B_SLEEP),
        .EXTERNAL_REFERENCE_SELECT(EXTERNAL_REFERENCE_SELECT)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end
    function automatic logic [8:0] cexp(logic [7:0] a, logic [7:0] b, logic [7:0] c);
        return {a[2:0], b[7], b[6], b[6], b[3], b[2], c[2]};
    endfunction
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WRITE = 1;
        @(posedge CLOCK);
        #1;
    endtask
    task idle;
        REG_WRITE = 0;
        @(posedge CLOCK);
        #1;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        REG_WRITE = 0;
        REG_ADDR = a;
        REG_READ = 1;
        @(posedge CLOCK);
        #1;
        chk("rvalid", 16'h0001, REG_RDATA_VALID);
        chk("rdata", e, REG_RDATA);
        REG_READ = 0;
        @(posedge CLOCK);
        #1;
        chk("rvalid", 16'h0000, REG_RDATA_VALID);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(3000 * 50);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge CLOCK);
        #1;
        RESET = 0;
        chk("ctrl", 16'h0020, ctrl);
        for (int i = 0; i < 7; i++) rd(8'h14 + 8'(i), i == 4 ? 8'h83 : 8'h00);
        rd(8'h1b, 8'h00);
        $display("test reset values done");
        wr(8'h15, 8'haa);
        wr(8'h16, 8'hf8);
        wr(8'h17, 8'h28);
        idle;
        chk("offset_a", 16'h0000, OFFSET_A);
        chk("offset_b", 16'h0000, OFFSET_B);
        wr(8'h14, 8'h5c);
        chk("load", 16'h0001, OFFSET_LOAD);
        idle;
        chk("offset_a", 16'h1f5c, OFFSET_A);
        chk("offset_b", 16'h05aa, OFFSET_B);
        wr(8'h16, 8'h08);
        wr(8'h14, 8'h01);
        idle;
        chk("offset_a", 16'h0101, OFFSET_A);
        rd(8'h16, 8'h08);
        $display("test offsets done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h17, v17[i]);
            wr(8'h18, v18[i]);
            wr(8'h19, v19[i]);
            idle;
            chk("ctrl", cexp(v17[i],v18[i],v19[i]), ctrl);
        end
        wr(8'h17, 8'h04);
        SERIAL_READ_DATA = 1;
        idle;
        idle;
        chk("alarm_pin", 16'h0001, ALARM_PIN_OUT);
        wr(8'h17, 8'h00);
        idle;
        idle;
        chk("alarm_pin", 16'h0000, ALARM_PIN_OUT);
        SERIAL_READ_DATA = 0;
        ALARM_LEVEL = 1;
        idle;
        idle;
        chk("alarm_pin", 16'h0001, ALARM_PIN_OUT);
        $display("test controls done");
        finish_test;
    end
endmodule
bind dopcr_regs dopcr_props u_props (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE),
    .SERIAL_READ_DATA(SERIAL_READ_DATA),
    .ALARM_LEVEL(ALARM_LEVEL),
    .OFFSET_A(OFFSET_A),
    .OFFSET_B(OFFSET_B),
    .OFFSET_LOAD(OFFSET_LOAD),
    .FOUR_WIRE_PORT_SELECT(FOUR_WIRE_PORT_SELECT),
    .ALARM_PIN_OUT(ALARM_PIN_OUT),
    .CLKPATH_SLEEP_A(CLKPATH_SLEEP_A),
    .CLKPATH_SLEEP_B(CLKPATH_SLEEP_B),
    .TEMP_SENSOR_ENABLE(TEMP_SENSOR_ENABLE),
    .CLOCK_RECEIVER_SLEEP(CLOCK_RECEIVER_SLEEP),
    .SYNC_STROBE_INPUT_SLEEP(SYNC_STROBE_INPUT_SLEEP),
    .DAC_CORE_A_SLEEP(DAC_CORE_A_SLEEP),
    .DAC_CORE_B_SLEEP(DAC_CORE_B_SLEEP),
    .EXTERNAL_REFERENCE_SELECT(EXTERNAL_REFERENCE_SELECT)
);
`default_nettype wire
